// >>> logic/gfx_unit_pkg.sv
// shared constants for the graphics integer unit: opcodes, pixel sizes,
// register offsets, field positions and reset values.
// assumes a single 20 MHz core clock and a plain register port.
package gfx_unit_pkg;

  // operation codes presented by the issue logic
  localparam logic [3:0] OP_ADD     = 4'h0;  // source_one + source_two
  localparam logic [3:0] OP_SUB     = 4'h1;  // source_one - source_two
  localparam logic [3:0] OP_MOVE    = 4'h2;  // add with zero_register
  localparam logic [3:0] OP_ZCHK16  = 4'h3;  // four 16-bit z compares
  localparam logic [3:0] OP_ZCHK32  = 4'h4;  // two 32-bit z compares
  localparam logic [3:0] OP_PADD    = 4'h5;  // add with pixel merge
  localparam logic [3:0] OP_ZADD    = 4'h6;  // add with z merge
  localparam logic [3:0] OP_MERGE_OR = 4'h7; // or with merge accumulator
  localparam logic [3:0] OP_PSTORE  = 4'h8;  // masked pixel store

  // pixel_size_field encodings
  localparam logic [1:0] PIXEL_SIZE_8  = 2'h0;
  localparam logic [1:0] PIXEL_SIZE_16 = 2'h1;
  localparam logic [1:0] PIXEL_SIZE_32 = 2'h2;

  // merge shift amounts (field sizes)
  localparam int PADD_SHIFT_8  = 8;
  localparam int PADD_SHIFT_16 = 6;
  localparam int PADD_SHIFT_32 = 8;
  localparam int ZADD_SHIFT    = 16;

  // register map (byte addresses on the register port)
  localparam logic [3:0] ADDR_STATUS    = 4'h0;
  localparam logic [3:0] ADDR_MERGE_LO  = 4'h4;
  localparam logic [3:0] ADDR_MERGE_HI  = 4'h8;

  // status word fields
  localparam int PIXEL_SIZE_LSB = 0;  // pixel_size_field [1:0]
  localparam int PIXEL_MASK_LSB = 8;  // pixel_mask_field [15:8]

  // reset values
  localparam logic [1:0]  PIXEL_SIZE_RESET = 2'h0;
  localparam logic [7:0]  PIXEL_MASK_RESET = 8'h00;
  localparam logic [63:0] MERGE_RESET = 64'h0000_0000_0000_0000;

endpackage

// >>> logic/graphics_integer_unit.sv
// graphics integer unit: long-integer add/sub, z-buffer checks, merge
// accumulator and pixel mask for a core's floating-point side.
// assumes issue logic presents one operation per cycle with operands read
// from the floating-point register file, and writes results back there.
//
// Summary of operation
// - operands and results live in fp registers
// - width qualifier selects 32 or 64 bits
// - pipelined op emits last stage, then refills
// - no condition code change, no traps
// - moves are adds with the zero register
// - 64-bit merge accumulator collects addition results
// - only two adds and or touch merge
// - z element size chosen by instruction only
// - pixel size comes from status register field
// - z checks compare unsigned, several in parallel
// - mask bit set when new distance smaller
// - z check shifts old mask bits right
// - pixel store uses mask for byte enables
// - pixel add shifts merge by field size
// - z add shifts 16, loads upper halves
`timescale 1ns/100ps

module graphics_integer_unit (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // issue side
  input  wire logic        op_valid_i,     // one-cycle operation strobe
  input  wire logic [3:0]  op_code_i,      // gfx_unit_pkg::OP_*
  input  wire logic        op_double_i,    // double_width_qualifier
  input  wire logic        op_pipe_i,      // pipelined form
  input  wire logic [4:0]  op_dest_i,      // destination register index
  input  wire logic [63:0] source_one_i,
  input  wire logic [63:0] source_two_i,
  // write-back side
  output logic             res_valid_o,    // one-cycle write strobe
  output logic [4:0]       res_dest_o,
  output logic [63:0]      res_data_o,
  output logic             res_double_o,   // 64-bit write when high
  output logic [7:0]       store_en_o,     // byte enables of a store
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic [31:0]      reg_rdata_o
);

  // state
  logic [1:0]  pixel_size_field_reg;   // status register pixel size
  logic [1:0]  pixel_size_field_next;
  logic [7:0]  pixel_mask_field_reg;   // accumulated compare bits
  logic [7:0]  pixel_mask_field_next;
  logic [63:0] merge_reg;              // merge accumulator
  logic [63:0] merge_next;
  logic [63:0] stage_reg;              // last pipeline stage result
  logic [63:0] stage_next;
  logic        stage_double_reg;       // width of the staged result
  logic        stage_double_next;
  logic [63:0] res_data_next;
  logic        res_double_next;
  logic [7:0]  store_en_next;
  logic [31:0] rdata_next;

  // decode
  // codes 9..15 match none of these and fall through to the adder
  wire is_add   = (op_code_i == gfx_unit_pkg::OP_ADD);
  wire is_sub   = (op_code_i == gfx_unit_pkg::OP_SUB);
  wire is_move  = (op_code_i == gfx_unit_pkg::OP_MOVE);
  wire is_z16   = (op_code_i == gfx_unit_pkg::OP_ZCHK16);
  wire is_z32   = (op_code_i == gfx_unit_pkg::OP_ZCHK32);
  wire is_padd  = (op_code_i == gfx_unit_pkg::OP_PADD);
  wire is_zadd  = (op_code_i == gfx_unit_pkg::OP_ZADD);
  wire is_or    = (op_code_i == gfx_unit_pkg::OP_MERGE_OR);
  wire is_store = (op_code_i == gfx_unit_pkg::OP_PSTORE);
  wire fire     = op_valid_i;

  // merge adds always work on the full 64-bit word
  wire merge_op = is_padd | is_zadd;
  wire use_double = op_double_i | merge_op | is_z16 | is_z32;

  // move substitutes the always-zero register for the second operand
  wire [63:0] operand_two = is_move ? 64'h0000_0000_0000_0000
                                    : source_two_i;

  // one adder serves add, move and both merge adds, a subtracter serves sub; no carry-out or
  // overflow is kept, so no flag or trap can ever be raised
  wire [63:0] sum_full  = source_one_i + operand_two;
  wire [63:0] diff_full = source_one_i - operand_two;
  wire [63:0] arith     = is_sub ? diff_full : sum_full;
  // single width keeps only the low register of the pair
  wire [63:0] arith_w   = use_double ? arith
                                     : {32'h0000_0000, arith[31:0]};

  // parallel unsigned compares; the point to be drawn is source_two,
  // the stored z-buffer distance is source_one
  // nets rather than variables: each generate lane drives only its own
  // slice, and several drivers of one net stay legal that way
  wire [3:0]  lt16;                   // drawn nearer, 16-bit lanes
  wire [1:0]  lt32;                   // drawn nearer, 32-bit lanes
  wire [63:0] min16;                  // nearer distance, 16-bit lanes
  wire [63:0] min32;                  // nearer distance, 32-bit lanes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_z16
      wire [15:0] drawn  = source_two_i[gi*16 +: 16];
      wire [15:0] stored = source_one_i[gi*16 +: 16];
      assign lt16[gi] = (drawn < stored);
      assign min16[gi*16 +: 16] = lt16[gi] ? drawn : stored;
    end
    for (gi = 0; gi < 2; gi++) begin : g_z32
      wire [31:0] drawn  = source_two_i[gi*32 +: 32];
      wire [31:0] stored = source_one_i[gi*32 +: 32];
      assign lt32[gi] = (drawn < stored);
      assign min32[gi*32 +: 32] = lt32[gi] ? drawn : stored;
    end
  endgenerate

  // new mask: old bits move right, new bits fill the vacated top
  wire [7:0] mask_z16 = {lt16, pixel_mask_field_reg[7:4]};
  wire [7:0] mask_z32 = {lt32, pixel_mask_field_reg[7:2]};

  // store byte enables widen each mask bit to its pixel's bytes
  // reserved size code 3 falls to the default and acts as 32-bit pixels
  logic [7:0] mask_bytes;
  always_comb begin
    unique case (pixel_size_field_reg)
      gfx_unit_pkg::PIXEL_SIZE_8:
        mask_bytes = pixel_mask_field_reg;
      gfx_unit_pkg::PIXEL_SIZE_16:
        mask_bytes = {{2{pixel_mask_field_reg[3]}},
                      {2{pixel_mask_field_reg[2]}},
                      {2{pixel_mask_field_reg[1]}},
                      {2{pixel_mask_field_reg[0]}}};
      default:
        mask_bytes = {{4{pixel_mask_field_reg[1]}},
                      {4{pixel_mask_field_reg[0]}}};
    endcase
  end

  // pixel add: shift by field size, then drop truncated sums into the
  // top of each interpolated field; lower fraction bits are discarded
  // all fields share one 64-bit add, so a carry can spill into the next
  // field up; software has to allow for it
  logic [63:0] merge_padd;
  always_comb begin
    merge_padd = merge_reg;
    unique case (pixel_size_field_reg)
      gfx_unit_pkg::PIXEL_SIZE_8: begin
        merge_padd = merge_reg >> gfx_unit_pkg::PADD_SHIFT_8;
        merge_padd[63:56] = sum_full[63:56];
        merge_padd[47:40] = sum_full[47:40];
        merge_padd[31:24] = sum_full[31:24];
        merge_padd[15:8]  = sum_full[15:8];
      end
      gfx_unit_pkg::PIXEL_SIZE_16: begin
        merge_padd = merge_reg >> gfx_unit_pkg::PADD_SHIFT_16;
        merge_padd[63:58] = sum_full[63:58];
        merge_padd[47:42] = sum_full[47:42];
        merge_padd[31:26] = sum_full[31:26];
        merge_padd[15:10] = sum_full[15:10];
      end
      default: begin
        merge_padd = merge_reg >> gfx_unit_pkg::PADD_SHIFT_32;
        merge_padd[63:56] = sum_full[63:56];
        merge_padd[31:24] = sum_full[31:24];
      end
    endcase
  end

  // z add: shift 16 then load the upper half of each 32-bit sum
  // meant for 16-bit z-buffers; 32-bit ones interpolate with plain adds
  logic [63:0] merge_zadd;
  always_comb begin
    merge_zadd = merge_reg >> gfx_unit_pkg::ZADD_SHIFT;
    merge_zadd[31:16] = sum_full[31:16];
    merge_zadd[63:48] = sum_full[63:48];
  end

  // result of the operation before any pipelining
  // the or instruction reads the merge word but never writes it back
  logic [63:0] op_result;
  always_comb begin
    if (is_z16) begin
      op_result = min16;
    end else if (is_z32) begin
      op_result = min32;
    end else if (is_or) begin
      op_result = source_one_i | merge_reg;
    end else if (is_store) begin
      op_result = source_one_i;
    end else begin
      op_result = arith_w;
    end
  end

  // next-state selection; hardware updates beat a register write in the
  // same cycle so that no compare result is lost; merge takes no register write
  // software may preload the mask, e.g. to clear it before a run of checks
  wire sw_status = reg_write_i && (reg_addr_i == gfx_unit_pkg::ADDR_STATUS);
  always_comb begin
    pixel_size_field_next = pixel_size_field_reg;
    pixel_mask_field_next = pixel_mask_field_reg;
    merge_next            = merge_reg;
    stage_next            = stage_reg;
    stage_double_next     = stage_double_reg;
    res_data_next         = res_data_o;
    res_double_next       = res_double_o;
    store_en_next         = 8'h00;
    if (sw_status) begin
      pixel_size_field_next = reg_wdata_i[gfx_unit_pkg::PIXEL_SIZE_LSB +: 2];
      pixel_mask_field_next = reg_wdata_i[gfx_unit_pkg::PIXEL_MASK_LSB +: 8];
    end
    if (fire) begin
      // mask and merge only change for their own instructions
      if (is_z16) begin
        pixel_mask_field_next = mask_z16;
      end else if (is_z32) begin
        pixel_mask_field_next = mask_z32;
      end
      if (is_padd) begin
        merge_next = merge_padd;
      end else if (is_zadd) begin
        merge_next = merge_zadd;
      end
      // a store reads the mask and leaves it for the next run of checks
      if (is_store) begin
        store_en_next = mask_bytes;
      end
      if (op_pipe_i) begin
        // emit the old last stage, then load the new result
        res_data_next     = stage_reg;
        res_double_next   = stage_double_reg;
        stage_next        = op_result;
        stage_double_next = use_double;
      end else begin
        res_data_next   = op_result;
        res_double_next = use_double;
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    unique case (reg_addr_i)
      gfx_unit_pkg::ADDR_STATUS:
        rdata_next = {16'h0000, pixel_mask_field_reg, 6'h00,
                      pixel_size_field_reg};
      gfx_unit_pkg::ADDR_MERGE_LO: rdata_next = merge_reg[31:0];
      gfx_unit_pkg::ADDR_MERGE_HI: rdata_next = merge_reg[63:32];
      default:                     rdata_next = 32'h0000_0000;
    endcase
  end

  // state registers
  // the stage starts empty and narrow, so the first pipelined op after
  // reset writes back zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pixel_size_field_reg <= gfx_unit_pkg::PIXEL_SIZE_RESET;
      pixel_mask_field_reg <= gfx_unit_pkg::PIXEL_MASK_RESET;
      merge_reg            <= gfx_unit_pkg::MERGE_RESET;
      stage_reg            <= gfx_unit_pkg::MERGE_RESET;
      stage_double_reg     <= 1'b0;
    end else begin
      pixel_size_field_reg <= pixel_size_field_next;
      pixel_mask_field_reg <= pixel_mask_field_next;
      merge_reg            <= merge_next;
      stage_reg            <= stage_next;
      stage_double_reg     <= stage_double_next;
    end
  end

  // write-back registers: a result appears the cycle after issue
  // the pipelined form relies on dest differing from both sources
  // res_dest_o keeps the last destination so a slow reader still sees it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      res_valid_o  <= 1'b0;
      res_dest_o   <= 5'h00;
      res_data_o   <= gfx_unit_pkg::MERGE_RESET;
      res_double_o <= 1'b0;
      store_en_o   <= 8'h00;
    end else begin
      res_valid_o  <= fire;
      res_dest_o   <= fire ? op_dest_i : res_dest_o;
      res_data_o   <= res_data_next;
      res_double_o <= res_double_next;
      store_en_o   <= store_en_next;
    end
  end

  // read data stands in the cycle after the read strobe only
  // zero outside the answer cycle lets several slaves share one read bus
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= reg_read_i ? rdata_next : 32'h0000_0000;
    end
  end

endmodule // graphics_integer_unit

// >>> tb/fp_regfile_model.sv
// floating-point register file model fed by the write-back port.
// assumes one write a cycle; index zero stays the zero register.
`timescale 1ns/100ps
module fp_regfile_model (
  input wire logic        clk_i,
  input wire logic        wr_en_i,
  input wire logic [4:0]  wr_idx_i,
  input wire logic [63:0] wr_data_i,
  input wire logic        wr_dbl_i
);
  logic [63:0] regs [32] = '{default: 64'h0}; // file contents
  // a narrow write leaves the upper half alone
  always @(posedge clk_i) begin
    if (wr_en_i && wr_idx_i != 5'h00 && wr_dbl_i) begin
      regs[wr_idx_i] <= wr_data_i;
    end else if (wr_en_i && wr_idx_i != 5'h00) begin
      regs[wr_idx_i][31:0] <= wr_data_i[31:0];
    end
  end
endmodule // fp_regfile_model

// >>> tb/gfx_unit_chk.sv
// port assertions for the graphics integer unit.
// assumes one clock and an active high asynchronous reset.
`timescale 1ns/100ps
module gfx_unit_chk (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        op_valid_i,
  input wire logic [3:0]  op_code_i,
  input wire logic        op_double_i,
  input wire logic        op_pipe_i,
  input wire logic [4:0]  op_dest_i,
  input wire logic [63:0] source_one_i,
  input wire logic [63:0] source_two_i,
  input wire logic        res_valid_o,
  input wire logic [4:0]  res_dest_o,
  input wire logic [63:0] res_data_o,
  input wire logic        res_double_o,
  input wire logic [7:0]  store_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // decoded issue kinds; only scalar ops answer with their own result
  wire logic sc     = op_valid_i && !op_pipe_i;
  wire logic is_add = op_code_i == gfx_unit_pkg::OP_ADD;
  wire logic is_sub = op_code_i == gfx_unit_pkg::OP_SUB;
  wire logic is_mov = op_code_i == gfx_unit_pkg::OP_MOVE;
  // a pipelined double add; two of them one stage-idle cycle apart form a chain
  sequence s_pipe_add;
    op_valid_i && op_pipe_i && op_double_i && is_add;
  endsequence
  // a cycle that leaves the last stage alone
  sequence s_stage_idle;
    !(op_valid_i && op_pipe_i);
  endsequence
  a_result_strobe: assert property (op_valid_i |=> res_valid_o)
    else $error("no result strobe after an op");
  a_no_stray: assert property (!op_valid_i |=> !res_valid_o)
    else $error("result strobe without an op");
  a_dest_follows: assert property (op_valid_i |=>
    res_dest_o == $past(op_dest_i)) else $error("wrong destination");
  a_add_sum: assert property (sc && is_add && op_double_i |=>
    res_data_o == $past(source_one_i) + $past(source_two_i))
    else $error("wrong sum");
  a_sub_diff: assert property (sc && is_sub && op_double_i |=>
    res_data_o == $past(source_one_i) - $past(source_two_i))
    else $error("wrong difference");
  a_narrow_width: assert property (sc && !op_double_i &&
    (is_add || is_sub || is_mov) |=>
    res_data_o[63:32] == 32'h0 && !res_double_o)
    else $error("narrow result not 32 bits");
  a_move_copy: assert property (sc && is_mov && op_double_i |=>
    res_data_o == $past(source_one_i)) else $error("move altered data");
  a_pipe_chain: assert property (s_pipe_add ##1 s_stage_idle ##1
    s_pipe_add |=>
    res_data_o == $past(source_one_i, 3) + $past(source_two_i, 3))
    else $error("pipeline stage lost");
  a_store_quiet: assert property (!(op_valid_i &&
    op_code_i == gfx_unit_pkg::OP_PSTORE) |=> store_en_o == 8'h00)
    else $error("store enables without a store");
endmodule // gfx_unit_chk

// >>> tb/test_graphics_integer_unit.sv
// self-checking bench for the graphics integer unit.
// assumes the package, checker and register file model are compiled first.
`timescale 1ns/100ps
module test_graphics_integer_unit;
  logic        clk_i = 1'b0, reset_i = 1'b1, op_valid_i = 1'b0;
  logic        op_double_i = 1'b0, op_pipe_i = 1'b0;
  logic        reg_write_i = 1'b0, reg_read_i = 1'b0;
  logic [3:0]  op_code_i = 4'h0, reg_addr_i = 4'h0;
  logic [4:0]  op_dest_i = 5'h00, res_dest_o;
  logic [63:0] source_one_i = 64'h0, source_two_i = 64'h0, res_data_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic        res_valid_o, res_double_o;
  logic [7:0]  store_en_o, en_seen;
  logic [7:0]  en_tab [3] = '{8'h94, 8'h30, 8'h00}; // per pixel size
  int          fails = 0, comparisons = 0;
  graphics_integer_unit graphics_integer_unit_i (.*);
  fp_regfile_model fp_regfile_model_i (.clk_i, .wr_en_i(res_valid_o),
    .wr_idx_i(res_dest_o), .wr_data_i(res_data_o), .wr_dbl_i(res_double_o));
  // core clock, 50 ns period
  always #25 clk_i = ~clk_i;
  // compare one value and count it
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one op into destination 7, never a source index
  task automatic op(input logic [3:0] c, input logic d, input logic p,
                    input logic [63:0] a, b, e);
    @(posedge clk_i);
    {op_valid_i, op_code_i, op_double_i, op_pipe_i} <= {1'b1, c, d, p};
    {op_dest_i, source_one_i, source_two_i} <= {5'h07, a, b};
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    en_seen = store_en_o;
    chk(res_data_o, e);
  endtask
  // one register write, or one read compared with v
  task automatic reg_op(input logic w, input logic [3:0] ad,
                        input logic [31:0] v);
    @(posedge clk_i);
    {reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} <= {w, !w, ad, v};
    @(posedge clk_i);
    {reg_write_i, reg_read_i} <= 2'b00;
    #1;
    if (!w) begin
      chk({32'h0, reg_rdata_o}, {32'h0, v});
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence: reset, arithmetic, pipeline, z checks, merge
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    reg_op(1'b0, gfx_unit_pkg::ADDR_STATUS, 32'h0);
    reg_op(1'b0, gfx_unit_pkg::ADDR_MERGE_LO, 32'h0);
    reg_op(1'b0, 4'hC, 32'h0);
    op(gfx_unit_pkg::OP_ADD, 1'b1, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF,
       64'h1, 64'h0);
    op(gfx_unit_pkg::OP_ADD, 1'b0, 1'b0, 64'h0000_0001_FFFF_FFFF,
       64'h1, 64'h0);
    op(gfx_unit_pkg::OP_SUB, 1'b1, 1'b0, 64'h5, 64'h7,
       64'hFFFF_FFFF_FFFF_FFFE);
    op(gfx_unit_pkg::OP_MOVE, 1'b1, 1'b0, 64'h0123_4567_89AB_CDEF,
       64'h1111, 64'h0123_4567_89AB_CDEF);
    @(posedge clk_i);
    #1;
    chk(fp_regfile_model_i.regs[7], 64'h0123_4567_89AB_CDEF);
    op(gfx_unit_pkg::OP_ADD, 1'b1, 1'b1, 64'h10, 64'h20, 64'h0);
    op(gfx_unit_pkg::OP_ADD, 1'b1, 1'b1, 64'h3, 64'h4, 64'h30);
    op(gfx_unit_pkg::OP_SUB, 1'b1, 1'b1, 64'h9, 64'h1, 64'h7);
    op(gfx_unit_pkg::OP_ZCHK16, 1'b1, 1'b0, 64'h0010_0010_0010_0010,
       64'h8000_0005_0010_0001, 64'h0010_0005_0010_0001);
    op(gfx_unit_pkg::OP_ZCHK32, 1'b1, 1'b0, 64'h0000_0100_0000_0100,
       64'h0000_0001_0000_0200, 64'h0000_0001_0000_0100);
    reg_op(1'b0, gfx_unit_pkg::ADDR_STATUS, 32'h0000_9400);
    for (int i = 0; i < 3; i++) begin
      reg_op(1'b1, gfx_unit_pkg::ADDR_STATUS,
             {16'h0000, 8'h94, 6'h00, i[1:0]});
      op(gfx_unit_pkg::OP_PSTORE, 1'b1, 1'b0, 64'hAA,
         64'h0, 64'hAA);
      chk({56'h0, en_seen}, {56'h0, en_tab[i]});
    end
    reg_op(1'b0, gfx_unit_pkg::ADDR_STATUS, 32'h0000_9402);
    reg_op(1'b1, gfx_unit_pkg::ADDR_STATUS, 32'h0000_9401);
    op(gfx_unit_pkg::OP_PADD, 1'b1, 1'b0, 64'hFC00_FC00_FC00_FC00,
       64'h0, 64'hFC00_FC00_FC00_FC00);
    op(gfx_unit_pkg::OP_PADD, 1'b1, 1'b0, 64'h0, 64'h0, 64'h0);
    reg_op(1'b0, gfx_unit_pkg::ADDR_MERGE_LO, 32'h03F0_03F0);
    op(gfx_unit_pkg::OP_ZADD, 1'b1, 1'b0, 64'h1234_0000_5678_0000,
       64'h0001_0000_0001_0000, 64'h1235_0000_5679_0000);
    op(gfx_unit_pkg::OP_MERGE_OR, 1'b1, 1'b0, 64'h1, 64'h0,
       64'h1235_03F0_5679_03F1);
    reg_op(1'b1, gfx_unit_pkg::ADDR_MERGE_HI, 32'hFFFF_FFFF);
    reg_op(1'b0, gfx_unit_pkg::ADDR_MERGE_HI, 32'h1235_03F0);
    reg_op(1'b0, gfx_unit_pkg::ADDR_MERGE_LO, 32'h5679_03F0);
    report_and_stop();
  end
endmodule // test_graphics_integer_unit
bind graphics_integer_unit gfx_unit_chk gfx_unit_chk_i (.*);
